/* File: test/dsa_accumulator_saturate_round_tb.sv */
// Purpose: Self-checking bench for the accumulator saturate, round and write-back datapath.
// Assumes: Registers over classic Wishbone; operations arrive as one-cycle requests.
// Notes: The clock enable is held high, so freezing is not exercised here.
module dsa_accumulator_saturate_round_tb import dsa_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	// ********************************
	// Signals and instances
	// ********************************
	logic sys_clk, rstn, cyc, stb, we, ack, trap, irq, cv, rr, t, ts;
	logic [9:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd, r1, r2, c0, m_count;
	logic [15:0] w13, m_addr, m_data, saddr;
	logic [39:0] av;
	dsa_op_s op;
	dsa_xwr_s xwr, xs;
	int fail_count, n_compared, i;
	integer seed;
	dsa_kind_e kl[4] = '{OP_MPY, OP_MPYN, OP_ED, OP_EUCLIDEAN_DISTANCE_ACCUMULATE};
	logic [15:0] t_ctl[5] = '{16'h00B0, 16'h00A0, 16'h00A0, 16'h0070, 16'h0020};
	logic t_tgt[5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	logic [39:0] t_start[5] = '{40'h7F_FFFF_FFFF, 40'h00_7FFF_FFFF, 40'hFF_8000_0000,
		40'h80_0000_0000, 40'h7F_FFFF_FFFF};
	logic [39:0] t_add[5] = '{40'h1, 40'h1, 40'hFF_FFFF_FFFF, 40'hFF_FFFF_FFFF, 40'h1};
	logic [39:0] t_res[5] = '{SAT_POS_931, SAT_POS_131, SAT_NEG_131, SAT_NEG_931,
		40'h80_0000_0000};
	logic [15:0] t_st[5] = '{16'hAC00, 16'h2400, 16'h2400, 16'h5C00, 16'hEC00};

	dsa_accum dsa_accum_i (.sys_clk_i(sys_clk), .rstn_i(rstn), .ce_i(1'b1), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .op_i(op), .xwr_o(xwr), .w13_o(w13),
		.trap_req_o(trap), .irq_o(irq));
	dsa_xbus_model dsa_xbus_model_i (.sys_clk_i(sys_clk), .rstn_i(rstn), .xwr_i(xwr),
		.addr_o(m_addr), .data_o(m_data), .count_o(m_count));

	always #20 sys_clk = ~sys_clk;

	// ********************************
	// Tasks and expectations
	// ********************************
	task check(input logic [39:0] seen, input logic [39:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task report_and_stop;
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Called just after a rising edge; ends on the edge after the idle cycle.
	task bus(input logic w, input logic [7:0] idx, input logic [3:0] s, input logic [15:0] d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= s;
		wdat <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			fail_count++;
			report_and_stop();
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge sys_clk);
	endtask

	task set_acc(input logic tg, input logic [39:0] v);
		logic [7:0] b;
		b = tg ? IDX_ACCB_LO : IDX_ACCA_LO;
		bus(1'b1, b, 4'h3, v[15:0]);
		bus(1'b1, b + 8'h02, 4'h3, v[31:16]);
		bus(1'b1, b + 8'h04, 4'h1, {8'h00, v[39:32]});
	endtask

	task get_acc(input logic tg);
		logic [7:0] b;
		b = tg ? IDX_ACCB_LO : IDX_ACCA_LO;
		bus(1'b0, b, 4'hF, 16'h0000);
		av[15:0] = rd[15:0];
		bus(1'b0, b + 8'h02, 4'hF, 16'h0000);
		av[31:16] = rd[15:0];
		bus(1'b0, b + 8'h04, 4'hF, 16'h0000);
		av[39:32] = rd[7:0];
		check(rd[15:8], {8{av[39]}});
	endtask

	// The answer is sampled just after the taking edge, since it stands one cycle only.
	task do_op(input dsa_kind_e k, input logic tg, input logic [39:0] a, input dsa_wbmode_e m,
		input logic [15:0] sa);
		op <= '{1'b1, k, tg, a, m, sa};
		@(posedge sys_clk);
		op.valid <= 1'b0;
		#1;
		xs = xwr;
		ts = trap;
		@(posedge sys_clk);
	endtask

	function automatic logic [15:0] rnd_fn(input logic [39:0] a, input logic r, input logic c);
		if (!r) return a[31:16];
		if (c && a[15:0] == LOW_HALF) return a[31:16] + {15'h0000, a[16]};
		return a[31:16] + {15'h0000, a[15]};
	endfunction

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		{cyc, stb, we, adr, sel, wdat} = '0;
		op = '0;
		seed = 32'h4CE1;
		fail_count = 0;
		n_compared = 0;
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		bus(1'b0, IDX_CONTROL, 4'hF, 16'h0000);
		check(rd, {16'h0000, CC_RESET});
		bus(1'b0, IDX_STATUS, 4'hF, 16'h0000);
		check(rd, 32'h0);
		bus(1'b0, 8'h7F, 4'hF, 16'h0000);
		check(rd, 32'h0);
		// Rounding ties come first, then random words on both accumulators.
		for (i = 0; i < 14; i++) begin
			r1 = $random(seed);
			r2 = $random(seed);
			av = {r1[7:0], r2};
			if (i < 4) av[16:0] = {i[0], LOW_HALF};
			cv = (i < 4) ? i[1] : r1[8];
			rr = (i < 4) || r1[9];
			t = r1[10];
			saddr = r1[31:16];
			bus(1'b1, IDX_CONTROL, 4'h3, {10'h000, r1[11], 3'b000, cv, 1'b0});
			set_acc(t, av);
			c0 = m_count;
			do_op(rr ? OP_STORE_ACCUMULATOR_ROUNDED : OP_SAC, t, 40'h0, WB_NONE, saddr);
			check(xs.addr, saddr);
			check(xs.data, rnd_fn(av, rr, cv));
			check(xs.sat_en, r1[11]);
			check(m_count, c0 + 32'h1);
			check({m_addr, m_data}, {saddr, rnd_fn(av, rr, cv)});
		end
		bus(1'b1, IDX_CONTROL, 4'h3, CC_RESET);
		set_acc(1'b1, 40'h00_1234_C000);
		set_acc(1'b0, 40'h0);
		bus(1'b1, IDX_W13, 4'h3, 16'h0FFE);
		do_op(OP_MAC, 1'b0, 40'h00_0001_0000, WB_POSTINC, 16'h0000);
		check({xs.valid, xs.addr, xs.data}, {1'b1, 16'h0FFE, 16'h1235});
		check(w13, 16'h1000);
		check({m_addr, m_data}, {16'h0FFE, 16'h1235});
		do_op(OP_MAC, 1'b0, 40'h00_0001_0000, WB_DIRECT, 16'h0000);
		check(w13, 16'h1235);
		get_acc(1'b0);
		check(av, 40'h00_0002_0000);
		for (i = 0; i < 4; i++) begin
			do_op(kl[i], 1'b0, 40'h5, WB_POSTINC, 16'h0000);
			check({xs.valid, w13}, {1'b0, 16'h1235});
		end
		get_acc(1'b0);
		check(av, 40'h0A);
		// Saturation modes, catastrophic wrap with trap, sticky flags and interrupts.
		bus(1'b1, IDX_TRAP_CTL, 4'h3, 16'h0001);
		for (i = 0; i < 5; i++) begin
			t = t_tgt[i];
			bus(1'b1, IDX_CONTROL, 4'h3, t_ctl[i]);
			bus(1'b1, IDX_STATUS, 4'h2, 16'h0000);
			bus(1'b1, IDX_IRQ_MASK, 4'h3, (i == 1) ? 16'h0000 : 16'h0003);
			set_acc(t, t_start[i]);
			do_op(OP_MAC, t, t_add[i], WB_NONE, 16'h0000);
			check(ts, i == 4);
			get_acc(t);
			check(av, t_res[i]);
			bus(1'b0, IDX_STATUS, 4'hF, 16'h0000);
			check(rd[15:0], t_st[i]);
			check(irq, i != 1);
			bus(1'b0, IDX_IRQ_STAT, 4'hF, 16'h0000);
			check({rd[t + 2], rd[t]}, {i == 4, 1'b1});
			bus(1'b1, IDX_IRQ_STAT, 4'h3, 16'h000F);
			check(irq, 1'b0);
		end
		do_op(OP_MPY, 1'b0, 40'h5, WB_NONE, 16'h0000);
		bus(1'b0, IDX_STATUS, 4'hF, 16'h0000);
		check(rd[15:0], 16'h6C00);
		do_op(OP_MPY, 1'b1, 40'h5, WB_NONE, 16'h0000);
		bus(1'b0, IDX_STATUS, 4'hF, 16'h0000);
		check(rd[15:0], 16'h2400);
		report_and_stop();
	end
endmodule // dsa_accumulator_saturate_round_tb

/* File: test/dsa_xbus_model.sv */
// Purpose: Data-space write bus sink that records word writes arriving on the X bus.
// Assumes: One word write for each valid pulse, on the core clock.
// Notes: Only the last write and a running count are kept, which is all the bench needs.
module dsa_xbus_model
	import dsa_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire dsa_xwr_s xwr_i,
	output logic [15:0] addr_o,
	output logic [15:0] data_o,
	output logic [31:0] count_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********************************
	// Write capture
	// ********************************
	// The whole 16-bit address is kept, so writes into X and Y space alike are seen.
	// Capture happens mid-cycle, where the one-cycle valid pulse has settled, so the
	// bench sees the write at the rising edge that ends the pulse.
	always_ff @(negedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			addr_o <= 16'h0000;
			data_o <= 16'h0000;
			count_o <= 32'h0;
		end else if (xwr_i.valid) begin
			addr_o <= xwr_i.addr;
			data_o <= xwr_i.data;
			count_o <= count_o + 32'h1;
		end
	end
endmodule // dsa_xbus_model

/* File: verilog/dsa_accum.sv */
// Purpose: Accumulator saturation, overflow flags, rounding and write-back of a DSP core.
// Assumes: Core operations arrive on sys_clk_i from the decoder; no synchronisers needed.
// Notes: A core operation wins over a same-cycle software write to the same accumulator.
//
// The Wishbone interface to the registers was left to the implementer.

// Operation
// - Status shows OR of overflow and saturation flags
// - 9.31 mode saturates past bit 39, sticky flag
// - 1.31 mode saturates past bit 31, sticky flag
// - 1.31 mode never sets overflow flags
// - Catastrophic mode wraps and sets saturation flag
// - Trap enable raises trap on catastrophic overflow
// - MAC write-back of non-target high word, with exceptions
// - Write-back travels on X bus, full space
// - Direct mode writes rounded word to W13
// - Post-increment writes at W13, then adds two
// - Combinational round, mode from control bit
// - Round yields 16-bit fraction to write saturation
// - No rounding stores truncated high word
// - Conventional round adds bit 15
// - Convergent round ties on bit 16
// - Store writes truncated, rounded variant writes rounded
// - MAC write-back is always rounded
module dsa_accum
	import dsa_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire dsa_op_s op_i,
	output dsa_xwr_s xwr_o,
	output logic [15:0] w13_o,
	output logic trap_req_o,
	output logic irq_o
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// Round is pure logic: it only looks at the accumulator and the mode bit.
	function automatic logic [15:0] round_hi(input logic [39:0] acc, input logic conv);
		logic inc;
		inc = acc[15];
		if (conv && acc[15:0] == LOW_HALF) begin
			inc = acc[16];
		end
		return acc[31:16] + {15'h0000, inc};
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = nw[7:0];
		end
		if (sel[1]) begin
			r[15:8] = nw[15:8];
		end
		return r;
	endfunction

	// Guard bits carry data when they disagree with bit 31.
	function automatic logic guard_used(input logic [39:0] v);
		return !((v[39:31] == 9'h000) || (v[39:31] == 9'h1FF));
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	logic [39:0] acc_q [2];
	logic [1:0] ovf_q;
	logic [1:0] sat_q;
	logic [15:0] ctl_q;
	logic [15:0] w13_q;
	logic catastrophic_overflow_trap_enable_q;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_mask_q;
	dsa_xwr_s xwr_q;
	logic trap_q;
	logic irq_q;
	logic ack_q;
	logic [31:0] rdat_q;

	// ****************************************************************
	// Accumulate and saturate
	// ****************************************************************
	logic tgt;
	logic [39:0] acc_t;
	logic [40:0] sum;
	logic ovf39;
	logic big31;
	logic sat_en;
	logic acc_saturation_mode_select;
	logic [39:0] res;
	logic sat_hit;
	logic catas;
	logic arith;
	logic [15:0] wb_word;
	logic mac_wb;

	always_comb begin
		tgt = op_i.target;
		acc_t = acc_q[tgt];
		arith = op_i.valid && (op_i.kind inside {OP_MAC, OP_MPY, OP_MPYN, OP_ED, OP_EUCLIDEAN_DISTANCE_ACCUMULATE});
		if (op_i.kind inside {OP_MPY, OP_MPYN, OP_ED}) begin
			sum = {op_i.addend[39], op_i.addend};
		end else begin
			sum = {acc_t[39], acc_t} + {op_i.addend[39], op_i.addend};
		end
		ovf39 = sum[40] ^ sum[39];
		big31 = !((sum[40:31] == 10'h000) || (sum[40:31] == 10'h3FF));
		sat_en = tgt ? ctl_q[CC_ACC_B_SATURATION_ENABLE] : ctl_q[CC_ACC_A_SATURATION_ENABLE];
		acc_saturation_mode_select = ctl_q[CC_ACC_SATURATION_MODE_SELECT];
		res = sum[39:0];
		sat_hit = 1'b0;
		catas = 1'b0;
		if (sat_en && acc_saturation_mode_select) begin
			if (ovf39) begin
				res = sum[40] ? SAT_NEG_931 : SAT_POS_931;
				sat_hit = 1'b1;
			end
		end else if (sat_en) begin
			if (big31) begin
				res = sum[40] ? SAT_NEG_131 : SAT_POS_131;
				sat_hit = 1'b1;
			end
		end else begin
			sat_hit = ovf39;
			catas = ovf39;
		end
		// Write-back reads the other accumulator, which this operation leaves alone.
		wb_word = round_hi(acc_q[!tgt], ctl_q[CC_RND]);
		mac_wb = op_i.valid && op_i.kind == OP_MAC && op_i.wb_mode != WB_NONE;
	end

	// ****************************************************************
	// Wishbone decode
	// ****************************************************************
	logic acc_req;
	logic wr_en;
	logic [7:0] idx;
	logic [15:0] sr_word;

	always_comb begin
		acc_req = wb_cyc_i && wb_stb_i && !ack_q;
		wr_en = acc_req && wb_we_i;
		idx = wb_adr_i[9:2];
		sr_word = 16'h0000;
		sr_word[SR_OA] = ovf_q[0];
		sr_word[SR_OB] = ovf_q[1];
		sr_word[SR_SA] = sat_q[0];
		sr_word[SR_SB] = sat_q[1];
		sr_word[SR_OAB] = ovf_q[0] | ovf_q[1];
		sr_word[SR_SAB] = sat_q[0] | sat_q[1];
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_q <= acc_req;
			if (acc_req && !wb_we_i) begin
				case (idx)
					IDX_W13: rdat_q <= {16'h0000, w13_q};
					IDX_ACCA_LO: rdat_q <= {16'h0000, acc_q[0][15:0]};
					IDX_ACCA_HI: rdat_q <= {16'h0000, acc_q[0][31:16]};
					IDX_ACCA_UP: rdat_q <= {16'h0000, {8{acc_q[0][39]}}, acc_q[0][39:32]};
					IDX_ACCB_LO: rdat_q <= {16'h0000, acc_q[1][15:0]};
					IDX_ACCB_HI: rdat_q <= {16'h0000, acc_q[1][31:16]};
					IDX_ACCB_UP: rdat_q <= {16'h0000, {8{acc_q[1][39]}}, acc_q[1][39:32]};
					IDX_STATUS: rdat_q <= {16'h0000, sr_word};
					IDX_CONTROL: rdat_q <= {16'h0000, ctl_q};
					IDX_IRQ_STAT: rdat_q <= {28'h000_0000, irq_stat_q};
					IDX_IRQ_MASK: rdat_q <= {28'h000_0000, irq_mask_q};
					IDX_TRAP_CTL: rdat_q <= {31'h0000_0000, catastrophic_overflow_trap_enable_q};
					default: rdat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ****************************************************************
	// Accumulators and flags
	// ****************************************************************
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acc_q[0] <= ACC_RESET;
			acc_q[1] <= ACC_RESET;
		end else if (ce_i) begin
			for (int i = 0; i < 2; i++) begin
				if (arith && tgt == 1'(i)) begin
					acc_q[i] <= res;
				end else if (wr_en) begin
					if (idx == IDX_ACCA_LO + 8'(i * 6)) begin
						acc_q[i][15:0] <= merge16(acc_q[i][15:0], wb_dat_i, wb_sel_i);
					end else if (idx == IDX_ACCA_HI + 8'(i * 6)) begin
						acc_q[i][31:16] <= merge16(acc_q[i][31:16], wb_dat_i, wb_sel_i);
					end else if (idx == IDX_ACCA_UP + 8'(i * 6) && wb_sel_i[0]) begin
						acc_q[i][39:32] <= wb_dat_i[7:0];
					end
				end
			end
		end
	end

	// Saturation flags are sticky; a set in the same cycle as a clear wins.
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sat_q <= 2'b00;
			ovf_q <= 2'b00;
		end else if (ce_i) begin
			for (int i = 0; i < 2; i++) begin
				if (arith && tgt == 1'(i) && sat_hit) begin
					sat_q[i] <= 1'b1;
				end else if (wr_en && idx == IDX_STATUS && wb_sel_i[1]) begin
					sat_q[i] <= wb_dat_i[SR_SA - i];
				end
				if (arith && tgt == 1'(i)) begin
					ovf_q[i] <= (sat_en && !acc_saturation_mode_select) ? 1'b0 : guard_used(res);
				end
			end
		end
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctl_q <= CC_RESET;
			catastrophic_overflow_trap_enable_q <= 1'b0;
			irq_mask_q <= IRQ_RESET;
		end else if (ce_i && wr_en) begin
			if (idx == IDX_CONTROL) begin
				ctl_q <= merge16(ctl_q, wb_dat_i, wb_sel_i) & CC_WR_MASK;
			end
			if (idx == IDX_TRAP_CTL && wb_sel_i[0]) begin
				catastrophic_overflow_trap_enable_q <= wb_dat_i[TC_CATASTROPHIC_OVERFLOW_TRAP_ENABLE];
			end
			if (idx == IDX_IRQ_MASK && wb_sel_i[0]) begin
				irq_mask_q <= wb_dat_i[3:0];
			end
		end
	end

	// ****************************************************************
	// Write-back, store and W13
	// ****************************************************************
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			w13_q <= W13_RESET;
		end else if (ce_i) begin
			if (mac_wb && op_i.wb_mode == WB_DIRECT) begin
				w13_q <= wb_word;
			end else if (mac_wb && op_i.wb_mode == WB_POSTINC) begin
				w13_q <= w13_q + W13_STEP;
			end else if (wr_en && idx == IDX_W13) begin
				w13_q <= merge16(w13_q, wb_dat_i, wb_sel_i);
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			xwr_q <= '0;
		end else if (ce_i) begin
			xwr_q.valid <= 1'b0;
			xwr_q.sat_en <= ctl_q[CC_DATA_WRITE_SATURATION_ENABLE];
			if (mac_wb && op_i.wb_mode == WB_POSTINC) begin
				xwr_q.valid <= 1'b1;
				xwr_q.addr <= w13_q;
				xwr_q.data <= wb_word;
			end else if (op_i.valid && op_i.kind == OP_SAC) begin
				xwr_q.valid <= 1'b1;
				xwr_q.addr <= op_i.store_addr;
				xwr_q.data <= acc_q[tgt][31:16];
			end else if (op_i.valid && op_i.kind == OP_STORE_ACCUMULATOR_ROUNDED) begin
				xwr_q.valid <= 1'b1;
				xwr_q.addr <= op_i.store_addr;
				xwr_q.data <= round_hi(acc_t, ctl_q[CC_RND]);
			end
		end
	end

	// ****************************************************************
	// Trap and interrupt
	// ****************************************************************
	logic [3:0] irq_ev;

	always_comb begin
		irq_ev = 4'h0;
		if (arith) begin
			irq_ev[{1'b0, tgt}] = sat_hit;
			irq_ev[{1'b1, tgt}] = catas;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			trap_q <= 1'b0;
			irq_stat_q <= IRQ_RESET;
			irq_q <= 1'b0;
		end else if (ce_i) begin
			trap_q <= arith && catas && catastrophic_overflow_trap_enable_q;
			if (wr_en && idx == IDX_IRQ_STAT && wb_sel_i[0]) begin
				irq_stat_q <= (irq_stat_q & ~wb_dat_i[3:0]) | irq_ev;
			end else begin
				irq_stat_q <= irq_stat_q | irq_ev;
			end
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign xwr_o = xwr_q;
	assign w13_o = w13_q;
	assign trap_req_o = trap_q;
	assign irq_o = irq_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);

	logic step;
	assign step = ce_i && arith;

	// The combined bits are checked where software sees them, through the read mux.
	a_combined_status: assert property (
		ce_i && acc_req && !wb_we_i && idx == IDX_STATUS |=>
		wb_dat_o[SR_OAB] == $past(ovf_q[0] | ovf_q[1])
		&& wb_dat_o[SR_SAB] == $past(sat_q[0] | sat_q[1]))
		else $error("combined flag wrong");
	a_full_sat_load: assert property (
		step && sat_en && acc_saturation_mode_select && ovf39 |=>
		acc_q[$past(tgt)] == ($past(sum[40]) ? SAT_NEG_931 : SAT_POS_931)
		&& sat_q[$past(tgt)]) else $error("9.31 saturation wrong");
	a_half_sat_load: assert property (
		step && sat_en && !acc_saturation_mode_select && big31 |=>
		acc_q[$past(tgt)] == ($past(sum[40]) ? SAT_NEG_131 : SAT_POS_131)
		&& sat_q[$past(tgt)]) else $error("1.31 saturation wrong");
	a_half_no_ovf: assert property (
		step && sat_en && !acc_saturation_mode_select |=> !ovf_q[$past(tgt)]
		&& (!sr_word[SR_OAB] || ovf_q[!$past(tgt)])) else $error("overflow set in 1.31");
	a_catas_wrap: assert property (
		step && !sat_en && ovf39 |=>
		acc_q[$past(tgt)] == $past(sum[39:0]) && sat_q[$past(tgt)]) else $error("wrap wrong");
	a_trap_raise: assert property (
		step && !sat_en && ovf39 && catastrophic_overflow_trap_enable_q |=> trap_req_o) else $error("trap missing");
	a_postinc_w13: assert property (
		ce_i && mac_wb && op_i.wb_mode == WB_POSTINC |=>
		xwr_o.valid && xwr_o.addr == $past(w13_q) && w13_q == $past(w13_q) + W13_STEP
		&& xwr_o.data == $past(wb_word)) else $error("post-increment wrong");
	a_direct_w13: assert property (
		ce_i && mac_wb && op_i.wb_mode == WB_DIRECT |=>
		w13_o == $past(wb_word) && !xwr_o.valid) else $error("direct write wrong");
	a_store_trunc: assert property (
		ce_i && op_i.valid && op_i.kind == OP_SAC |=>
		xwr_o.valid && xwr_o.data == $past(acc_t[31:16])) else $error("truncation wrong");
	a_round_tie: assert property (
		ce_i && op_i.valid && op_i.kind == OP_STORE_ACCUMULATOR_ROUNDED
		&& acc_t[15:0] == LOW_HALF && ctl_q[CC_RND] |=>
		xwr_o.data == $past(acc_t[31:16]) + {15'h0000, $past(acc_t[16])})
		else $error("convergent tie wrong");

	c_full_sat: cover property (step && sat_en && acc_saturation_mode_select && ovf39);
	c_half_sat: cover property (step && sat_en && !acc_saturation_mode_select && big31);
	c_trap: cover property (trap_req_o);
	c_postinc: cover property (ce_i && mac_wb && op_i.wb_mode == WB_POSTINC);

endmodule // dsa_accum

/* File: verilog/dsa_pkg.sv */
// Purpose: Shared constants and carrier types of the accumulator saturate and round datapath.
// Assumes: One 25 MHz core clock; registers reached over classic Wishbone, index times four.
// Notes: Register offsets are word indices; the byte address is four times the index.
package dsa_pkg;

	// ****************************************************************
	// Register indices
	// ****************************************************************
	localparam logic [7:0] IDX_W13 = 8'h1A;
	localparam logic [7:0] IDX_ACCA_LO = 8'h22;
	localparam logic [7:0] IDX_ACCA_HI = 8'h24;
	localparam logic [7:0] IDX_ACCA_UP = 8'h26;
	localparam logic [7:0] IDX_ACCB_LO = 8'h28;
	localparam logic [7:0] IDX_ACCB_HI = 8'h2A;
	localparam logic [7:0] IDX_ACCB_UP = 8'h2C;
	localparam logic [7:0] IDX_STATUS = 8'h42;
	localparam logic [7:0] IDX_CONTROL = 8'h44;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h60;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h61;
	localparam logic [7:0] IDX_TRAP_CTL = 8'h62;

	// ****************************************************************
	// Field positions and reset values
	// ****************************************************************
	localparam int SR_OA = 15;
	localparam int SR_OB = 14;
	localparam int SR_SA = 13;
	localparam int SR_SB = 12;
	localparam int SR_OAB = 11;
	localparam int SR_SAB = 10;
	localparam int CC_ACC_A_SATURATION_ENABLE = 7;
	localparam int CC_ACC_B_SATURATION_ENABLE = 6;
	localparam int CC_DATA_WRITE_SATURATION_ENABLE = 5;
	localparam int CC_ACC_SATURATION_MODE_SELECT = 4;
	localparam int CC_RND = 1;
	localparam int TC_CATASTROPHIC_OVERFLOW_TRAP_ENABLE = 0;
	localparam logic [15:0] CC_RESET = 16'h0020;
	localparam logic [15:0] CC_WR_MASK = 16'h00F2;
	localparam logic [15:0] W13_RESET = 16'h0000;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;

	// ****************************************************************
	// Datapath constants
	// ****************************************************************
	localparam logic [39:0] SAT_POS_931 = 40'h7F_FFFF_FFFF;
	localparam logic [39:0] SAT_NEG_931 = 40'h80_0000_0000;
	localparam logic [39:0] SAT_POS_131 = 40'h00_7FFF_FFFF;
	localparam logic [39:0] SAT_NEG_131 = 40'hFF_8000_0000;
	localparam logic [15:0] LOW_HALF = 16'h8000;
	localparam logic [15:0] W13_STEP = 16'h0002;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	typedef enum logic [2:0] {
		OP_MAC,
		OP_MPY,
		OP_MPYN,
		OP_ED,
		OP_EUCLIDEAN_DISTANCE_ACCUMULATE,
		OP_SAC,
		OP_STORE_ACCUMULATOR_ROUNDED
	} dsa_kind_e;

	typedef enum logic [1:0] {
		WB_NONE,
		WB_DIRECT,
		WB_POSTINC
	} dsa_wbmode_e;

	typedef struct packed {
		logic valid;
		dsa_kind_e kind;
		logic target;
		logic [39:0] addend;
		dsa_wbmode_e wb_mode;
		logic [15:0] store_addr;
	} dsa_op_s;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
		logic [15:0] data;
		logic sat_en;
	} dsa_xwr_s;

endpackage
